// *** hw/cgl_pkg.sv ***
// Purpose: constants and types for the counter gate, latch and compare block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: control word travels as a packed struct
package cgl_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOAD = 8'h04;
  localparam logic [7:0] OFF_END = 8'h08;
  localparam logic [7:0] OFF_CMP = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_LATCH = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1C;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0FFF;
  localparam logic [31:0] LOAD_RST = 32'h0000_0000;
  localparam logic [31:0] END_RST = 32'h0000_0064;
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic signed [31:0] CNT_MAX = 32'sh7FFF_FFFF;
  localparam logic signed [31:0] CNT_MIN = 32'sh8000_0000;
  localparam logic signed [31:0] CNT_ONE = 32'sh0000_0001;
  // flags register bit positions
  localparam int FLG_CMP = 0;
  localparam int FLG_DO = 1;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CGL_CONT = 2'h0, CGL_ONCE = 2'h1, CGL_PERIOD = 2'h2} cgl_mode_t;
  typedef enum logic [1:0] {CGL_NONE = 2'h0, CGL_FWD = 2'h1, CGL_BWD = 2'h2} cgl_dir_t;
  typedef enum logic [1:0] {CGL_NOCMP = 2'h0, CGL_GE = 2'h1, CGL_LE = 2'h2} cgl_omode_t;
  // gray order: closed, open, auto closed
  typedef enum logic [1:0] {CGL_CLOSED = 2'h0, CGL_OPEN = 2'h1, CGL_AUTO = 2'h3} cgl_gate_t;
  typedef struct packed {
    logic [19:0] rsvd;
    logic run;
    logic plain_out;
    logic ctrl_do;
    cgl_omode_t omode;
    cgl_dir_t dir;
    cgl_mode_t mode;
    logic gate_stop;
    logic hardware_gate_en;
    logic software_gate_bit;
  } cgl_ctrl_t;
  // sticky event bits, bit 0 is cmp
  typedef struct packed {
    logic gclose;
    logic latch;
    logic uflow;
    logic oflow;
    logic cmp;
  } cgl_ev_t;
endpackage

// *** hw/cgl_counter.sv ***
// Purpose: gated 32-bit up/down counter with latch and comparator
// Assumes: count pulses, gate and latch inputs synchronous to mclk_i
// Notes: APB answers in the access cycle, read data taken at setup
//
// Our own choices: the placing of the registers and the APB slave port.
module cgl_counter
  import cgl_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // field side
  input wire logic count_up_i,
  input wire logic count_dn_i,
  input wire logic hardware_gate_i,
  input wire logic latch_i,
  output logic dout_o,
  output logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  cgl_ctrl_t ctrl;
  logic signed [31:0] load;
  logic signed [31:0] end_val;
  logic signed [31:0] cmp_val;
  logic signed [31:0] cnt;
  logic signed [31:0] latched_count_value;
  cgl_ev_t status;
  cgl_ev_t mask;
  logic compare_status_flag;
  logic output_state_flag;
  cgl_gate_t gate;
  logic hw_q;
  logic sw_q;
  logic latch_q;
  logic cond_q;
  logic [4:0] rd_clr;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire setup_rd = psel_i & ~penable_i & ~pwrite_i;
  wire hit_ctrl = paddr_i == OFF_CTRL;
  wire hit_load = paddr_i == OFF_LOAD;
  wire hit_end = paddr_i == OFF_END;
  wire hit_cmp = paddr_i == OFF_CMP;
  wire hit_cnt = paddr_i == OFF_COUNT;
  wire hit_lat = paddr_i == OFF_LATCH;
  wire hit_sts = paddr_i == OFF_STATUS;
  wire hit_msk = paddr_i == OFF_MASK;
  wire hit_flg = paddr_i == OFF_FLAGS;
  wire mapped = hit_ctrl | hit_load | hit_end | hit_cmp | hit_cnt
              | hit_lat | hit_sts | hit_msk | hit_flg;
  wire sts_rd_done = acc & ~pwrite_i & hit_sts;
  wire flg_clr = wr & hit_flg & pwdata_i[FLG_CMP];

  // no wait states; error only for holes in the map
  assign pready_o = acc;
  assign pslverr_o = acc & ~mapped;

  // read mux, sampled into prdata_o during the setup cycle
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) rdata = ctrl;
    if (hit_load) rdata = load;
    if (hit_end) rdata = end_val;
    if (hit_cmp) rdata = cmp_val;
    if (hit_cnt) rdata = cnt;
    if (hit_lat) rdata = latched_count_value;
    if (hit_sts) rdata = {27'h0, status};
    if (hit_msk) rdata = {27'h0, mask};
    if (hit_flg) rdata = {30'h0, output_state_flag, compare_status_flag};
  end

  // ---------------------------------------------------------------
  // gate logic
  // ---------------------------------------------------------------
  wire sw = ctrl.software_gate_bit;
  wire hw_rise = hardware_gate_i & ~hw_q;
  wire sw_rise = sw & ~sw_q;
  // pin level itself, so the gate opens at the edge that sees the rise
  wire hw_lvl = ctrl.hardware_gate_en ? hardware_gate_i : 1'b1;
  wire open_lvl = sw & hw_lvl & ctrl.run;
  // after an automatic close only a fresh rise may reopen
  wire reopen = ctrl.run & (ctrl.hardware_gate_en ? (hw_rise & sw) : sw_rise);
  wire igate = gate == CGL_OPEN;
  logic auto_cl;
  cgl_gate_t next_gate;

  always_comb
  begin
    next_gate = gate;
    case (gate)
      CGL_CLOSED: next_gate = open_lvl ? CGL_OPEN : CGL_CLOSED;
      CGL_OPEN:
      begin
        if (!open_lvl) next_gate = CGL_CLOSED;
        else if (auto_cl) next_gate = CGL_AUTO;
      end
      CGL_AUTO: next_gate = reopen ? CGL_OPEN : CGL_AUTO;
      default: next_gate = CGL_CLOSED;
    endcase
  end

  wire open_evt = (gate != CGL_OPEN) & (next_gate == CGL_OPEN);
  // with the hardware gate in use, a software rise only continues
  wire restart_edge = ctrl.hardware_gate_en ? hw_rise : sw_rise;
  wire restart = open_evt & ~ctrl.gate_stop & restart_edge;

  // ---------------------------------------------------------------
  // counter next value
  // ---------------------------------------------------------------
  wire up = count_up_i & ~count_dn_i;
  wire dn = count_dn_i & ~count_up_i;
  wire signed [31:0] end_m1 = end_val - CNT_ONE;
  wire signed [31:0] end_p1 = end_val + CNT_ONE;
  wire signed [31:0] cnt_inc = cnt + CNT_ONE;
  wire signed [31:0] cnt_dec = cnt - CNT_ONE;
  wire fwd = ctrl.dir == CGL_FWD;
  wire bwd = ctrl.dir == CGL_BWD;
  logic signed [31:0] next_cnt;
  logic ovf;
  logic unf;

  always_comb
  begin
    next_cnt = cnt;
    ovf = 1'b0;
    unf = 1'b0;
    auto_cl = 1'b0;
    if (restart)
      next_cnt = load;
    else if (igate && up)
    begin
      next_cnt = cnt_inc;
      ovf = (cnt == CNT_MAX) & ~bwd;
      case (ctrl.mode)
        CGL_PERIOD:
        begin
          if (fwd && cnt == end_m1) next_cnt = load;
          // backward mode lets the value climb freely
          if (bwd) next_cnt = cnt_inc;
        end
        CGL_ONCE:
        begin
          if (fwd && cnt == end_m1)
          begin
            next_cnt = load;
            auto_cl = 1'b1;
          end
          else auto_cl = ovf;
        end
        default: next_cnt = cnt_inc;
      endcase
    end
    else if (igate && dn)
    begin
      next_cnt = cnt_dec;
      unf = (cnt == CNT_MIN) & ~fwd;
      case (ctrl.mode)
        CGL_PERIOD:
        begin
          if (bwd && cnt == end_p1) next_cnt = load;
        end
        CGL_ONCE:
        begin
          if (bwd && cnt == end_p1)
          begin
            next_cnt = load;
            auto_cl = 1'b1;
          end
          else auto_cl = unf;
        end
        default: next_cnt = cnt_dec;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // comparator and output
  // ---------------------------------------------------------------
  wire no_cmp = ctrl.omode == CGL_NOCMP;
  wire cond = (ctrl.omode == CGL_GE) ? (cnt >= cmp_val)
            : (ctrl.omode == CGL_LE) ? (cnt <= cmp_val) : 1'b0;
  // control bit is ignored without comparison
  wire next_dout = no_cmp ? ctrl.plain_out : (ctrl.ctrl_do & cond);
  // hardware set wins; software clear only once condition is gone
  wire next_cflag = no_cmp ? 1'b0 : (cond | (compare_status_flag & ~flg_clr));
  wire latch_hit = latch_i & ~latch_q & igate;
  cgl_ev_t ev;
  assign ev = '{gclose: auto_cl & igate, latch: latch_hit, uflow: unf,
                oflow: ovf, cmp: cond & ~cond_q};

  // ---------------------------------------------------------------
  // registers written by software
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= cgl_ctrl_t'(CTRL_RST);
      load <= LOAD_RST;
      end_val <= END_RST;
      cmp_val <= CMP_RST;
      mask <= cgl_ev_t'(MASK_RST);
    end
    else if (wr)
    begin
      if (hit_ctrl) ctrl <= cgl_ctrl_t'(pwdata_i & CTRL_WMASK);
      if (hit_load) load <= pwdata_i;
      if (hit_end) end_val <= pwdata_i;
      if (hit_cmp) cmp_val <= pwdata_i;
      if (hit_msk) mask <= cgl_ev_t'(pwdata_i[4:0]);
    end
  end

  // ---------------------------------------------------------------
  // counting state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate <= CGL_CLOSED;
      cnt <= CNT_RST;
      hw_q <= 1'b0;
      sw_q <= 1'b0;
      latch_q <= 1'b0;
    end
    else
    begin
      gate <= next_gate;
      cnt <= next_cnt;
      hw_q <= hardware_gate_i;
      sw_q <= sw;
      latch_q <= latch_i;
    end
  end

  // latch is touched only by its own input, not by run changes
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) latched_count_value <= CNT_RST;
    else if (latch_hit) latched_count_value <= cnt;
  end

  // ---------------------------------------------------------------
  // flags, status and bus read data
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dout_o <= 1'b0;
      compare_status_flag <= 1'b0;
      output_state_flag <= 1'b0;
      cond_q <= 1'b0;
      status <= '0;
      rd_clr <= 5'h00;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      dout_o <= next_dout;
      compare_status_flag <= next_cflag;
      output_state_flag <= ~no_cmp & next_dout;
      cond_q <= cond;
      // only bits seen by the read are cleared, so new events survive
      status <= (status & ~(sts_rd_done ? rd_clr : 5'h00)) | ev;
      if (setup_rd)
      begin
        prdata_o <= rdata;
        rd_clr <= hit_sts ? rdata[4:0] : 5'h00;
      end
    end
  end

  assign irq_o = |(status & mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_closed_hold: assert property ((!igate && !restart) |=> $stable(cnt))
    else $error("counter moved with gate closed");
  a_fwd_reload: assert property ((igate && !restart && up && ctrl.mode == CGL_PERIOD
      && fwd && cnt == end_m1) |=> cnt == $past(load))
    else $error("forward reload missed");
  a_bwd_reload: assert property ((igate && !restart && dn && ctrl.mode == CGL_PERIOD
      && bwd && cnt == end_p1) |=> cnt == $past(load))
    else $error("backward reload missed");
  a_bwd_climb: assert property ((igate && !restart && up && ctrl.mode == CGL_PERIOD
      && bwd) |=> cnt == $past(cnt) + CNT_ONE)
    else $error("backward count clamped");
  a_hw_open: assert property ((gate == CGL_CLOSED && ctrl.hardware_gate_en && sw && ctrl.run
      && hw_rise) |=> igate)
    else $error("hardware rise did not open gate");
  a_sw_close: assert property (!sw |=> !igate)
    else $error("gate open without software gate");
  a_cancel_load: assert property ((open_evt && !ctrl.gate_stop && restart_edge)
      |=> cnt == $past(load))
    else $error("cancel did not reload");
  a_stop_keep: assert property ((open_evt && ctrl.gate_stop) |=> $stable(cnt))
    else $error("stop lost counter value");
  a_sw_continue: assert property ((open_evt && ctrl.hardware_gate_en && !hw_rise)
      |=> $stable(cnt))
    else $error("software rise reloaded counter");
  a_once_reopen: assert property ((gate == CGL_AUTO && !reopen) |=> !igate)
    else $error("auto closed gate reopened early");
  a_latch_copy: assert property (latch_hit |=> latched_count_value == $past(cnt))
    else $error("latch value wrong");
  a_nocmp_flags: assert property (no_cmp |=> !compare_status_flag && !output_state_flag
      && dout_o == $past(ctrl.plain_out))
    else $error("flags set without comparison");
  a_cmp_hold: assert property ((!no_cmp && cond) |=> compare_status_flag
      && dout_o == $past(ctrl.ctrl_do))
    else $error("compare output or flag dropped");
endmodule

// *** test/cgl_field_model.sv ***
// Purpose: field wiring model, encoder pulses, gate pin and latch pin
// Assumes: pins are sampled on the rising edge of mclk_i
// Notes: pins change by non-blocking assignment just after a rising edge
module cgl_field_model (
  // clock
  input wire logic mclk_i,
  // field pins
  output logic count_up_o,
  output logic count_dn_o,
  output logic hardware_gate_o,
  output logic latch_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels from time zero
  initial
  begin
    count_up_o = 1'b0;
    count_dn_o = 1'b0;
    hardware_gate_o = 1'b0;
    latch_o = 1'b0;
  end
  // n high cycles; quiet edges first so a freshly opened gate has settled
  task automatic pulse(input logic up, input int n);
    repeat (2) @(posedge mclk_i);
    count_up_o <= up;
    count_dn_o <= ~up;
    repeat (n) @(posedge mclk_i);
    count_up_o <= 1'b0;
    count_dn_o <= 1'b0;
  endtask
  // level change on the gate pin, one edge to be seen
  task automatic set_gate(input logic v);
    @(posedge mclk_i);
    hardware_gate_o <= v;
    @(posedge mclk_i);
  endtask
  // single rising edge on the latch pin
  task automatic latch_edge();
    @(posedge mclk_i);
    latch_o <= 1'b1;
    @(posedge mclk_i);
    latch_o <= 1'b0;
  endtask
endmodule

// *** test/tb_counter_gate_latch_compare.sv ***
// Purpose: self-checking bench for the counter gate, latch and compare block
// Assumes: APB master waits for pready, field pins come from the field model
// Notes: every scenario task judges its own results
module tb_counter_gate_latch_compare
  import cgl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic up;
  logic dn;
  logic hwg;
  logic lat;
  logic dout;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  // 100 ns period
  always #50 mclk = ~mclk;
  cgl_counter DUT (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .count_up_i(up), .count_dn_i(dn),
    .hardware_gate_i(hwg), .latch_i(lat), .dout_o(dout), .irq_o(irq));
  cgl_field_model fm (.mclk_i(mclk), .count_up_o(up), .count_dn_o(dn), .hardware_gate_o(hwg),
    .latch_o(lat));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // one transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, exp, rd);
  endtask
  // registered outputs trail the count by an edge
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // closing the software gate first makes the write a rising edge
  task automatic reopen(input logic [31:0] c);
    wr(OFF_CTRL, {c[31:1], 1'b0});
    wr(OFF_CTRL, c);
  endtask
  // control word, software gate and run set
  function automatic logic [31:0] ctl(input logic hw, stp, input cgl_mode_t m,
    input cgl_dir_t d, input cgl_omode_t o, input logic cdo);
    cgl_ctrl_t c;
    c = '0;
    c.software_gate_bit = 1'b1;
    c.hardware_gate_en = hw;
    c.gate_stop = stp;
    c.mode = m;
    c.dir = d;
    c.omode = o;
    c.ctrl_do = cdo;
    c.run = 1'b1;
    return c;
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] offs [9] = '{OFF_CTRL, OFF_LOAD, OFF_END, OFF_CMP, OFF_COUNT, OFF_LATCH,
      OFF_STATUS, OFF_MASK, OFF_FLAGS};
    logic [31:0] exps [9] = '{CTRL_RST, LOAD_RST, END_RST, CMP_RST, CNT_RST, 32'h0000_0000,
      32'h0000_0000, {27'h0, MASK_RST}, 32'h0000_0000};
    logic [31:0] rd;
    logic err;
    foreach (offs[i])
      rc(offs[i], exps[i], "reset value");
    apb(1'b0, 8'h24, 32'h0000_0000, rd, err);
    chkb("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0000_0000, rd);
    wr(OFF_CTRL, 32'hFFFF_F000);
    rc(OFF_CTRL, 32'h0000_0000, "reserved ctrl");
    $display("test reset done");
  endtask
  task automatic t_swgate();
    logic [31:0] c;
    c = ctl(1'b0, 1'b0, CGL_CONT, CGL_NONE, CGL_NOCMP, 1'b0);
    wr(OFF_LOAD, 32'h0000_0005);
    wr(OFF_CTRL, c);
    fm.pulse(1'b1, 3);
    rc(OFF_COUNT, 32'h0000_0008, "count open");
    wr(OFF_CTRL, {c[31:1], 1'b0});
    fm.pulse(1'b1, 2);
    rc(OFF_COUNT, 32'h0000_0008, "count closed");
    wr(OFF_CTRL, c);
    rc(OFF_COUNT, 32'h0000_0005, "cancel reload");
    c[2] = 1'b1;
    wr(OFF_CTRL, c);
    fm.pulse(1'b1, 2);
    reopen(c);
    fm.pulse(1'b0, 1);
    rc(OFF_COUNT, 32'h0000_0006, "stop resume");
    $display("test software gate done");
  endtask
  task automatic t_hwgate();
    logic [31:0] c;
    c = ctl(1'b1, 1'b0, CGL_CONT, CGL_NONE, CGL_NOCMP, 1'b0);
    wr(OFF_CTRL, c);
    fm.pulse(1'b1, 2);
    rc(OFF_COUNT, 32'h0000_0006, "pin low holds");
    fm.set_gate(1'b1);
    rc(OFF_COUNT, 32'h0000_0005, "pin rise reload");
    fm.pulse(1'b1, 2);
    fm.set_gate(1'b0);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0007, "pin fall closes");
    fm.set_gate(1'b1);
    fm.pulse(1'b1, 1);
    reopen(c);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0007, "sw rise continues");
    c[2] = 1'b1;
    wr(OFF_CTRL, c);
    fm.set_gate(1'b0);
    fm.set_gate(1'b1);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0008, "pin rise continues");
    reopen(c);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0009, "stop sw rise");
    fm.set_gate(1'b0);
    $display("test hardware gate done");
  endtask
  task automatic t_period();
    logic [31:0] c;
    c = ctl(1'b0, 1'b0, CGL_PERIOD, CGL_FWD, CGL_NOCMP, 1'b0);
    wr(OFF_END, 32'h0000_0008);
    reopen(c);
    fm.pulse(1'b1, 2);
    rc(OFF_COUNT, 32'h0000_0007, "fwd end minus one");
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0005, "fwd reload");
    c = ctl(1'b0, 1'b0, CGL_PERIOD, CGL_BWD, CGL_NOCMP, 1'b0);
    wr(OFF_END, 32'h0000_0002);
    reopen(c);
    fm.pulse(1'b0, 2);
    rc(OFF_COUNT, 32'h0000_0003, "bwd end plus one");
    fm.pulse(1'b0, 1);
    rc(OFF_COUNT, 32'h0000_0005, "bwd reload");
    wr(OFF_LOAD, CNT_MAX);
    reopen(c);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, CNT_MIN, "bwd past upper");
    fm.pulse(1'b0, 1);
    rc(OFF_COUNT, CNT_MAX, "bwd wrap below");
    rc(OFF_STATUS, 32'h0000_0004, "underflow event");
    wr(OFF_LOAD, 32'h0000_0005);
    $display("test periodic done");
  endtask
  task automatic t_latch();
    logic [31:0] c;
    logic [31:0] rd;
    logic err;
    c = ctl(1'b0, 1'b0, CGL_CONT, CGL_NONE, CGL_NOCMP, 1'b0);
    reopen(c);
    fm.pulse(1'b1, 4);
    wr(OFF_MASK, 32'h0000_0008);
    apb(1'b0, OFF_STATUS, 32'h0000_0000, rd, err);
    fm.latch_edge();
    rc(OFF_LATCH, 32'h0000_0009, "latched value");
    #1;
    chkb("irq raised", 1'b1, irq);
    rc(OFF_STATUS, 32'h0000_0008, "status latch");
    #1;
    chkb("irq cleared", 1'b0, irq);
    wr(OFF_CTRL, {c[31:12], 1'b0, c[10:0]});
    wr(OFF_CTRL, c);
    rc(OFF_LATCH, 32'h0000_0009, "latch after run");
    wr(OFF_CTRL, {c[31:1], 1'b0});
    fm.latch_edge();
    rc(OFF_LATCH, 32'h0000_0009, "latch gate closed");
    wr(OFF_MASK, 32'h0000_0000);
    wr(OFF_CTRL, c);
    fm.latch_edge();
    rc(OFF_LATCH, 32'h0000_0005, "latch after reload");
    #1;
    chkb("irq masked", 1'b0, irq);
    apb(1'b0, OFF_STATUS, 32'h0000_0000, rd, err);
    $display("test latch done");
  endtask
  task automatic t_compare();
    logic [31:0] c;
    logic [31:0] rd;
    logic err;
    wr(OFF_CMP, 32'h0000_0007);
    c = ctl(1'b0, 1'b0, CGL_CONT, CGL_NONE, CGL_GE, 1'b1);
    reopen(c);
    wr(OFF_MASK, 32'h0000_0001);
    settle();
    chkb("dout below", 1'b0, dout);
    fm.pulse(1'b1, 2);
    settle();
    chkb("dout reached", 1'b1, dout);
    chkb("irq compare", 1'b1, irq);
    wr(OFF_FLAGS, 32'h0000_0001);
    rc(OFF_FLAGS, 32'h0000_0003, "flags held");
    fm.pulse(1'b0, 1);
    settle();
    chkb("dout left", 1'b0, dout);
    wr(OFF_FLAGS, 32'h0000_0001);
    rc(OFF_FLAGS, 32'h0000_0000, "flag cleared");
    rc(OFF_STATUS, 32'h0000_0001, "status compare");
    c[8:7] = CGL_LE;
    wr(OFF_CTRL, c);
    settle();
    chkb("dout less equal", 1'b1, dout);
    c[8:7] = CGL_NOCMP;
    c[10] = 1'b1;
    wr(OFF_CTRL, c);
    settle();
    chkb("dout plain high", 1'b1, dout);
    rc(OFF_FLAGS, 32'h0000_0000, "flags plain");
    c[10] = 1'b0;
    wr(OFF_CTRL, c);
    settle();
    chkb("dout plain low", 1'b0, dout);
    wr(OFF_MASK, 32'h0000_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000, rd, err);
    $display("test compare done");
  endtask
  task automatic t_once();
    logic [31:0] c;
    c = ctl(1'b1, 1'b0, CGL_ONCE, CGL_FWD, CGL_NOCMP, 1'b0);
    wr(OFF_END, 32'h0000_0007);
    wr(OFF_CTRL, c);
    fm.set_gate(1'b1);
    fm.pulse(1'b1, 3);
    rc(OFF_COUNT, 32'h0000_0005, "once reload");
    rc(OFF_STATUS, 32'h0000_0010, "auto close");
    reopen(c);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0005, "sw rise stays shut");
    fm.set_gate(1'b0);
    fm.set_gate(1'b1);
    fm.pulse(1'b1, 1);
    rc(OFF_COUNT, 32'h0000_0006, "pin rise reopens");
    // backward once without the pin: the software rise reopens
    c = ctl(1'b0, 1'b0, CGL_ONCE, CGL_BWD, CGL_NOCMP, 1'b0);
    wr(OFF_END, 32'h0000_0003);
    reopen(c);
    fm.pulse(1'b0, 3);
    rc(OFF_COUNT, 32'h0000_0005, "once bwd reload");
    rc(OFF_STATUS, 32'h0000_0010, "once bwd close");
    reopen(c);
    fm.pulse(1'b0, 1);
    rc(OFF_COUNT, 32'h0000_0004, "sw rise reopens");
    $display("test count once done");
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence after a two-cycle reset
  initial
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_swgate();
    t_hwgate();
    t_period();
    t_latch();
    t_compare();
    t_once();
    complete_run();
  end
  // watchdog: the scenarios need well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    complete_run();
  end
endmodule
